// >>> logic/acs_pkg.sv
// shared constants and types for the converter start and serial readout block
package acs_pkg;

    localparam int DATA_W        = 8;      // result width
    localparam int FIFO_DEPTH    = 8;      // result buffer depth
    localparam int CNT_W         = 12;     // width of the sequencing counter

    localparam int CLK_PERIOD_NS = 20;     // sys_clk_in period
    localparam int CS_SAMPLE_NS  = 530;    // level check after the start edge
    localparam int RESULT_NS     = 330;    // result ready after the start edge
    localparam int PWRUP_EXT_NS  = 1000;   // power-up, external reference
    localparam int PWRUP_INT_NS  = 25000;  // power-up, on-chip reference

    // least times round up to whole cycles
    localparam int CS_SAMPLE_CYC = (CS_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESULT_CYC    = (RESULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_EXT_CYC = (PWRUP_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_INT_CYC = (PWRUP_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int BITS_PER_WORD = 8;      // serial bits per frame

    typedef enum logic [1:0] {
        PWR_DOWN,
        PWR_UP,
        PWR_IDLE,
        PWR_CONV
    } acs_pwr_type;

    typedef struct packed {
        logic              receive_frame_sync;  // low during a frame
        logic              data;                // serial data bit
        logic              data_oe_n;           // low while data is driven
    } acs_link_type;

    typedef struct packed {
        logic              cs_s1;
        logic              cs_s2;
        logic              cs_s3;
        logic              ck_s1;
        logic              ck_s2;
        logic              ck_s3;
        logic              ref_s1;
        logic              ref_s2;
        acs_pwr_type       pwr;
        logic [CNT_W-1:0]  cnt;
        logic              pend;
        logic              pushed;
        logic [DATA_W-1:0] hold;
        logic              active;
        logic [3:0]        bit_cnt;
        logic [DATA_W-1:0] shreg;
        acs_link_type      link;
        logic              powered;
        logic              busy;
    } acs_top_state_type;

    localparam acs_link_type LINK_RESET = '{receive_frame_sync: 1'b1, data: 1'b0, data_oe_n: 1'b1};

endpackage : acs_pkg

// >>> logic/acs_fifo.sv
// small synchronous fifo holding finished conversion results
module acs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,        // system clock
    input  wire logic             rst_n_in,      // sync reset, active low
    input  wire logic             in_valid_in,   // write request
    output logic                  in_ready_out,  // space available
    input  wire logic [WIDTH-1:0] in_data_in,    // write data
    output logic                  out_valid_out, // data available
    input  wire logic             out_ready_in,  // read request
    output logic [WIDTH-1:0]      out_data_out   // head of queue
);
    localparam int AW = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("acs_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } acs_fifo_state_type;

    acs_fifo_state_type q;
    acs_fifo_state_type d;
    logic               push;
    logic               pop;

    always_comb begin
        d             = q;
        in_ready_out  = (q.cnt != (AW+1)'(DEPTH));
        out_valid_out = (q.cnt != '0);
        out_data_out  = q.mem[q.rd];
        push          = in_valid_in && in_ready_out;
        pop           = out_valid_out && out_ready_in;
        if (push) begin
            d.mem[q.wr] = in_data_in;
            d.wr        = q.wr + AW'(1);
        end
        if (pop) begin
            d.rd = q.rd + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    chk_fifo_count : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        q.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");

endmodule : acs_fifo

// >>> logic/acs_top.sv
// conversion start sequencing, power-down control and serial result readout
module acs_top
    import acs_pkg::*;
#(
    parameter int PWRUP_EXT = PWRUP_EXT_CYC,
    parameter int PWRUP_INT = PWRUP_INT_CYC
) (
    input  wire logic              sys_clk_in,             // system clock, 50 MHz
    input  wire logic              rst_n_in,               // sync reset, active low
    input  wire logic              conversion_start_n_in,  // start pin, active low
    input  wire logic              sclk_in,                // serial clock pin from host
    input  wire logic              ext_ref_in,             // high when an external reference is used
    input  wire logic [DATA_W-1:0] conv_result_in,         // held sample from the analog core
    output acs_pkg::acs_link_type  link_out,               // frame sync, data, data enable
    output logic                   powered_out,            // core powered
    output logic                   converting_out          // conversion running
);
    import acs_pkg::*;

    if (PWRUP_EXT < 1 || PWRUP_INT < 1 || PWRUP_INT >= (1 << CNT_W) || PWRUP_EXT >= (1 << CNT_W)) begin : g_bad
        $error("acs_top: power-up counts out of range");
    end

    localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(CS_SAMPLE_CYC - 1);
    localparam logic [CNT_W-1:0] RESULT_LAST = CNT_W'(RESULT_CYC - 1);
    localparam logic [CNT_W-1:0] EXT_LAST    = CNT_W'(PWRUP_EXT - 1);
    localparam logic [CNT_W-1:0] INT_LAST    = CNT_W'(PWRUP_INT - 1);
    localparam logic [3:0]       LAST_BIT    = 4'(BITS_PER_WORD);

    acs_top_state_type q;
    acs_top_state_type d;

    logic              cs_fall;
    logic              cs_rise;
    logic              ck_rise;
    logic              ck_fall;
    logic              push_valid;
    logic              push_ready;
    logic              word_valid;
    logic              word_ready;
    logic [DATA_W-1:0] word;
    logic [CNT_W-1:0]  pwrup_last;

    // edges come from the second and third sync stages only
    assign cs_fall    = q.cs_s3 && !q.cs_s2;
    assign cs_rise    = !q.cs_s3 && q.cs_s2;
    assign ck_rise    = !q.ck_s3 && q.ck_s2;
    assign ck_fall    = q.ck_s3 && !q.ck_s2;
    assign pwrup_last = q.ref_s2 ? EXT_LAST : INT_LAST;
    assign push_valid = (q.pwr == PWR_CONV) && (q.cnt == RESULT_LAST) && !q.pushed;
    assign word_ready = !q.active && ck_rise;

    // finished results wait here until the host clocks them out
    acs_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_acs_fifo (
        .clk_in        (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (push_ready),
        .in_data_in    (q.hold),
        .out_valid_out (word_valid),
        .out_ready_in  (word_ready),
        .out_data_out  (word)
    );

    always_comb begin
        d        = q;
        d.cs_s1  = conversion_start_n_in;
        d.cs_s2  = q.cs_s1;
        d.cs_s3  = q.cs_s2;
        d.ck_s1  = sclk_in;
        d.ck_s2  = q.ck_s1;
        d.ck_s3  = q.ck_s2;
        d.ref_s1 = ext_ref_in;
        d.ref_s2 = q.ref_s1;

        case (q.pwr)
            PWR_DOWN: begin
                if (cs_rise) begin
                    d.pwr  = PWR_UP;
                    d.cnt  = '0;
                    d.pend = 1'b0;
                end
            end
            PWR_UP: begin
                if (cs_fall) begin
                    d.pend = 1'b1;
                end
                if (q.cnt == pwrup_last) begin
                    if (q.pend || cs_fall) begin
                        d.pwr    = PWR_CONV;
                        d.cnt    = '0;
                        d.pushed = 1'b0;
                        d.hold   = conv_result_in;
                    end else begin
                        d.pwr = PWR_IDLE;
                    end
                end else begin
                    d.cnt = q.cnt + CNT_W'(1);
                end
            end
            PWR_IDLE: begin
                if (cs_fall) begin
                    d.pwr    = PWR_CONV;
                    d.cnt    = '0;
                    d.pushed = 1'b0;
                    d.hold   = conv_result_in;
                end
            end
            PWR_CONV: begin
                if (push_valid) begin
                    // a full buffer stalls the conversion until a word drains
                    if (push_ready) begin
                        d.pushed = 1'b1;
                        d.cnt    = q.cnt + CNT_W'(1);
                    end
                end else if (q.cnt == SAMPLE_LAST) begin
                    d.pwr = q.cs_s2 ? PWR_IDLE : PWR_DOWN;
                end else begin
                    d.cnt = q.cnt + CNT_W'(1);
                end
            end
            default: begin
                d.pwr = PWR_DOWN;
            end
        endcase

        // readout runs whatever the power state of the core
        if (q.active && cs_fall) begin
            d.active                  = 1'b0;
            d.link.receive_frame_sync = 1'b1;
            d.link.data_oe_n          = 1'b1;
        end else if (!q.active) begin
            if (ck_rise && word_valid) begin
                d.active                  = 1'b1;
                d.link.receive_frame_sync = 1'b0;
                d.link.data_oe_n          = 1'b0;
                d.link.data               = word[DATA_W-1];
                d.shreg                   = {word[DATA_W-2:0], 1'b0};
                d.bit_cnt                 = 4'h1;
            end
        end else if (ck_rise) begin
            if (q.bit_cnt == LAST_BIT) begin
                d.active                  = 1'b0;
                d.link.receive_frame_sync = 1'b1;
                d.link.data_oe_n          = 1'b1;
            end else begin
                d.link.data = q.shreg[DATA_W-1];
                d.shreg     = {q.shreg[DATA_W-2:0], 1'b0};
                d.bit_cnt   = q.bit_cnt + 4'h1;
            end
        end else if (ck_fall && q.bit_cnt == LAST_BIT) begin
            d.link.data_oe_n = 1'b1;
        end

        d.powered = (d.pwr != PWR_DOWN);
        d.busy    = (d.pwr == PWR_CONV);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q         <= '0;
            q.cs_s1   <= 1'b1;
            q.cs_s2   <= 1'b1;
            q.cs_s3   <= 1'b1;
            q.pwr     <= PWR_DOWN;
            q.link    <= LINK_RESET;
        end else begin
            q <= d;
        end
    end

    assign link_out       = q.link;
    assign powered_out    = q.powered;
    assign converting_out = q.busy;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_sync_idle : assert property (!q.active |-> q.link.receive_frame_sync)
        else $error("frame sync low outside a frame");
    chk_data_hiz : assert property (!q.active |-> q.link.data_oe_n)
        else $error("data driven outside a frame");
    chk_power_up : assert property ((q.pwr == PWR_DOWN) && cs_rise |=> q.pwr == PWR_UP)
        else $error("start rise did not power up");
    chk_conv_start : assert property ((q.pwr == PWR_IDLE) && cs_fall |=> q.pwr == PWR_CONV && q.cnt == '0)
        else $error("start fall did not begin conversion");
    chk_mode_down : assert property ((q.pwr == PWR_CONV) && !push_valid && q.cnt == SAMPLE_LAST && !q.cs_s2
        |=> q.pwr == PWR_DOWN && !powered_out)
        else $error("low start level did not power down");
    chk_mode_stay : assert property ((q.pwr == PWR_CONV) && !push_valid && q.cnt == SAMPLE_LAST && q.cs_s2
        |=> q.pwr == PWR_IDLE ##1 powered_out)
        else $error("high start level did not keep core powered");
    chk_result_time : assert property ((q.pwr == PWR_IDLE) && cs_fall && push_ready
        |-> ##RESULT_CYC push_valid)
        else $error("result not offered on time");
    chk_frame_start : assert property (!q.active && ck_rise && word_valid && !cs_fall
        |=> !link_out.receive_frame_sync && !link_out.data_oe_n && link_out.data == $past(word[DATA_W-1]))
        else $error("frame start wrong");
    chk_data_stable : assert property (q.active && !ck_rise |=> $stable(link_out.data))
        else $error("data changed off a clock rise");
    chk_hiz_eighth : assert property (q.active && q.bit_cnt == LAST_BIT && ck_fall && !cs_fall
        |=> link_out.data_oe_n && !link_out.receive_frame_sync)
        else $error("data not released at eighth fall");
    chk_sync_ninth : assert property (q.active && q.bit_cnt == LAST_BIT && ck_rise |=> link_out.receive_frame_sync)
        else $error("frame sync not released at ninth rise");
    chk_abort_frame : assert property (q.active && cs_fall |=> link_out.receive_frame_sync && link_out.data_oe_n)
        else $error("start fall did not end frame");
    chk_defer_conv : assert property ((q.pwr == PWR_UP) && q.pend && q.cnt == pwrup_last |=> q.pwr == PWR_CONV)
        else $error("deferred conversion lost");

    cov_full_frame : cover property (q.active && q.bit_cnt == LAST_BIT && ck_rise);
    cov_aborted    : cover property (q.active && cs_fall);
    cov_power_down : cover property (q.pwr == PWR_CONV ##1 q.pwr == PWR_DOWN);
    cov_deferred   : cover property (q.pwr == PWR_UP && q.pend);

endmodule : acs_top

// >>> sim/acs_host_rx.sv
// host serial receive port model: burst serial clock, msb-first word capture
module acs_host_rx
    import acs_pkg::*;
(
    input  wire logic                  run_in,      // host lets the serial clock run
    input  wire acs_pkg::acs_link_type link_in,     // frame sync, data, data enable
    output logic                       sclk_out,    // serial clock to the device
    output logic [DATA_W-1:0]          word_out,    // last word shifted in
    output int                         n_words_out, // words received so far
    output int                         n_bits_out   // bits of the current frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wire_level;
    // a released pin shows the inverse bit so a stale value never reads as good
    assign wire_level = link_in.data_oe_n ? ~link_in.data : link_in.data;
    initial begin
        sclk_out = 1'b0;
        word_out = '0;
        n_words_out = 0;
        n_bits_out = 0;
        #7;
        forever begin
            // a new burst starts a fresh bit count, so a cut frame leaves nothing behind
            if (run_in !== 1'b1) begin
                wait (run_in === 1'b1);
                n_bits_out = 0;
            end
            #80 sclk_out = 1'b1;
            #80 sclk_out = 1'b0;
            // sample on the fall: the bit moved soon after the rise, the pin is released only after this fall
            if (link_in.receive_frame_sync === 1'b0) begin
                word_out = {word_out[DATA_W-2:0], wire_level};
                n_bits_out = n_bits_out + 1;
                if (n_bits_out == BITS_PER_WORD) begin
                    n_words_out = n_words_out + 1;
                    n_bits_out = 0;
                end
            end else begin
                n_bits_out = 0;
            end
        end
    end
endmodule : acs_host_rx

// >>> sim/acs_tb_top.sv
// self-checking bench for conversion start, power-down and serial readout
module acs_tb_top;
    import acs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW_EXT = 4;
    localparam int PW_INT = 8;
    logic              sys_clk_in;
    logic              rst_n_in;
    logic              start_n;
    logic              ext_ref;
    logic [DATA_W-1:0] result;
    acs_link_type      link;
    logic              powered;
    logic              converting;
    logic              sclk;
    logic              run;
    logic [DATA_W-1:0] word;
    int                n_words;
    int                n_bits;
    int                n_errors;
    int                n_checks;

    acs_top #(.PWRUP_EXT(PW_EXT), .PWRUP_INT(PW_INT)) u_acs_top (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .conversion_start_n_in(start_n), .sclk_in(sclk),
        .ext_ref_in(ext_ref), .conv_result_in(result), .link_out(link), .powered_out(powered),
        .converting_out(converting));
    acs_host_rx u_acs_host_rx (
        .run_in(run), .link_in(link), .sclk_out(sclk), .word_out(word), .n_words_out(n_words),
        .n_bits_out(n_bits));

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cycles

    function automatic logic probe(input int which);
        case (which)
            0: return converting;
            1: return powered;
            default: return link.receive_frame_sync;
        endcase
    endfunction : probe

    task automatic wait_for(input int which, input logic lvl, input int limit);
        for (int i = 0; i < limit && probe(which) !== lvl; i++) cycles(1);
    endtask : wait_for

    // hs keeps the core powered; full expects the conversion to stall on a full buffer
    task automatic convert(input logic [DATA_W-1:0] v, input bit hs, input bit full);
        result = v;
        start_n = 1'b0;
        wait_for(0, 1'b1, 10);
        check_bit(converting, 1'b1);
        if (hs) begin
            cycles(6);
            start_n = 1'b1;
        end
        wait_for(0, 1'b0, 60);
        check_bit(converting, full);
        cycles(3);
        check_bit(powered, hs);
    endtask : convert

    task automatic read_word(input logic [DATA_W-1:0] exp);
        int n0;
        n0 = n_words;
        run = 1'b1;
        cycles(1);
        for (int i = 0; i < 400 && n_bits < 3; i++) cycles(1);
        check_bit(link.receive_frame_sync, 1'b0);
        check_bit(link.data_oe_n, 1'b0);
        for (int i = 0; i < 400 && n_words == n0; i++) cycles(1);
        run = 1'b0;
        check_word(word, exp);
        cycles(12);
        check_bit(link.receive_frame_sync, 1'b1);
        check_bit(link.data_oe_n, 1'b1);
        cycles(2);
    endtask : read_word

    task automatic fill_and_drain;
        for (int i = 0; i < 9; i++) convert(8'h80 + DATA_W'(i), 1'b1, i == 8);
        check_bit(link.receive_frame_sync, 1'b1);
        for (int i = 0; i < 9; i++) read_word(8'h80 + DATA_W'(i));
    endtask : fill_and_drain

    task automatic abort_frame;
        convert(8'ha5, 1'b1, 1'b0);
        run = 1'b1;
        for (int i = 0; i < 400 && n_bits < 4; i++) cycles(1);
        run = 1'b0;
        cycles(5);
        check_bit(link.receive_frame_sync, 1'b0);
        result = 8'h3c;
        start_n = 1'b0;
        wait_for(2, 1'b1, 10);
        check_bit(link.receive_frame_sync, 1'b1);
        cycles(8);
        start_n = 1'b1;
        wait_for(0, 1'b0, 60);
        read_word(8'h3c);
    endtask : abort_frame

    // short start pulse during power-up: conversion waits for power-up to end
    task automatic deferred_start;
        start_n = 1'b1;
        cycles(2);
        start_n = 1'b0;
        wait_for(1, 1'b1, 20);
        check_bit(powered, 1'b1);
        check_bit(converting, 1'b0);
        wait_for(0, 1'b1, 30);
        check_bit(converting, 1'b1);
        wait_for(0, 1'b0, 60);
        cycles(3);
        check_bit(powered, 1'b0);
        read_word(8'h17);
    endtask : deferred_start

    initial begin
        #500000;
        n_errors++;
        print_verdict();
    end

    initial begin
        rst_n_in = 1'b0;
        start_n = 1'b1;
        ext_ref = 1'b0;
        result = '0;
        run = 1'b0;
        cycles(8);
        rst_n_in = 1'b1;
        cycles(1);
        check_bit(link.receive_frame_sync, 1'b1);
        check_bit(link.data_oe_n, 1'b1);
        check_bit(powered, 1'b0);
        start_n = 1'b0;
        cycles(40);
        check_bit(converting, 1'b0);
        start_n = 1'b1;
        wait_for(1, 1'b1, 20);
        check_bit(powered, 1'b1);
        cycles(PW_INT + 5);
        convert(8'h5a, 1'b1, 1'b0);
        read_word(8'h5a);
        ext_ref = 1'b1;
        fill_and_drain();
        abort_frame();
        convert(8'hc3, 1'b0, 1'b0);
        read_word(8'hc3);
        result = 8'h17;
        deferred_start();
        print_verdict();
    end
endmodule : acs_tb_top
